// ### rtl/rid_pkg.sv
// package: constants and types for the instruction format decoder
// Functional notes
// - 32-bit word, 6-bit major code at 31:26
// - memory: major, two selectors, 16-bit offset
// - address is base plus sign-extended offset
// - high-address load scales offset by 65536
// - function memory: 16-bit function replaces offset
// - jump group offset is only a hint
// - branch: major, one selector, 21-bit displacement
// - branch target: pointer plus displacement times four
// - integer operate: 7-bit function, three selectors
// - listed majors trap on unused function codes
// - first source selector 31 gives zero
// - bit 12 set selects zero-extended 8-bit literal
// - second register selector 31 gives zero
// - float operate: 11-bit function, three selectors
// - float selector 31 supplies zero
// - float operate never uses a literal
// - privileged call: 26-bit function field
// - all-zero major and function means halt
// - zero-register results discarded except unconditional transfers and privileged calls
package rid_pkg;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned RID_MAJ_HI = 31;
  localparam int unsigned RID_MAJ_LO = 26;
  localparam int unsigned RID_A_LO = 21;
  localparam int unsigned RID_B_LO = 16;
  localparam int unsigned RID_LIT_BIT = 12;
  localparam int unsigned RID_LIT_LO = 13;
  localparam int unsigned RID_IFUNC_LO = 5;
  localparam int unsigned RID_FFUNC_LO = 5;
  localparam logic [4:0] RID_ZERO_SEL = 5'h1F;
  localparam int unsigned RID_HIGH_SHIFT = 16;
  // ----------------------------------------
  // major codes
  // ----------------------------------------
  localparam logic [5:0] RID_OP_PRIV = 6'h00;
  localparam logic [5:0] RID_OP_ADDR_HIGH = 6'h09;
  localparam logic [5:0] RID_OP_FUNC_MEM = 6'h18;
  localparam logic [5:0] RID_OP_JUMP = 6'h1A;
  localparam logic [5:0] RID_OP_BR = 6'h30;
  localparam logic [5:0] RID_OP_BSR = 6'h34;
  localparam logic [5:0] RID_OP_IOP_LO = 6'h10;
  localparam logic [5:0] RID_OP_IOP_HI = 6'h13;
  localparam logic [5:0] RID_OP_FOP_LO = 6'h14;
  localparam logic [5:0] RID_OP_FOP_HI = 6'h17;
  localparam logic [5:0] RID_OP_BRANCH_LO = 6'h30;
  // majors whose unused function codes trap, one bit per code
  localparam logic [63:0] RID_TRAP_MAJORS = 64'h0000_0000_FA10_74FE;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    RID_FMT_MEM,
    RID_FMT_MEMFN,
    RID_FMT_BRANCH,
    RID_FMT_IOP,
    RID_FMT_FOP,
    RID_FMT_PRIV
  } rid_fmt_t;
  typedef struct packed {
    logic valid;
    rid_fmt_t fmt;
    logic [5:0] major;
    logic [4:0] sel_a;
    logic [4:0] sel_b;
    logic [4:0] sel_dest;
    logic [25:0] func;
    logic lit_used;
    logic halt;
    logic illegal;
    logic wb_discard;
  } rid_dec_t;
  typedef struct packed {
    logic [63:0] int_a;
    logic [63:0] int_b;
    logic [63:0] fp_a;
    logic [63:0] fp_b;
  } rid_regval_t;
  typedef struct packed {
    logic [63:0] src_a;
    logic [63:0] src_b;
    logic [63:0] vaddr;
  } rid_val_t;
endpackage : rid_pkg

// ### rtl/rid_decoder.sv
// module: registered instruction format decoder
`timescale 1ns/1ps
module rid_decoder (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic word_valid_i,
  input wire logic [31:0] word_i,
  input wire logic [63:0] instruction_pointer_i,
  input wire logic func_defined_i,
  input wire rid_pkg::rid_regval_t regval_i,
  output rid_pkg::rid_dec_t dec_o,
  output rid_pkg::rid_val_t val_o
);
  import rid_pkg::*;

  // ----------------------------------------
  // field extraction
  // ----------------------------------------
  wire logic [5:0] major_w = word_i[RID_MAJ_HI:RID_MAJ_LO];
  wire logic [4:0] sel_a_w = word_i[RID_A_LO+4:RID_A_LO];
  wire logic [4:0] sel_b_w = word_i[RID_B_LO+4:RID_B_LO];
  wire logic [4:0] sel_c_w = word_i[4:0];
  wire logic [15:0] disp16_w = word_i[15:0];
  wire logic [20:0] disp21_w = word_i[20:0];
  wire logic [6:0] ifunc_w = word_i[RID_IFUNC_LO+6:RID_IFUNC_LO];
  wire logic [10:0] ffunc_w = word_i[RID_FFUNC_LO+10:RID_FFUNC_LO];
  wire logic [25:0] pfunc_w = word_i[25:0];
  wire logic [7:0] lit_w = word_i[RID_LIT_LO+7:RID_LIT_LO];
  wire logic lit_bit_w = word_i[RID_LIT_BIT];

  // ----------------------------------------
  // format classification
  // ----------------------------------------
  wire logic trap_major_w = RID_TRAP_MAJORS[major_w];
  wire logic is_priv_w = (major_w == RID_OP_PRIV);
  wire logic is_fop_w = (major_w >= RID_OP_FOP_LO) && (major_w <= RID_OP_FOP_HI);
  wire logic is_iop_w = ((major_w >= RID_OP_IOP_LO) && (major_w <= RID_OP_IOP_HI)) || (trap_major_w && !is_fop_w);
  wire logic is_memfn_w = (major_w == RID_OP_FUNC_MEM);
  wire logic is_branch_w = (major_w >= RID_OP_BRANCH_LO);
  wire logic is_jump_w = (major_w == RID_OP_JUMP);
  rid_fmt_t fmt_w;
  assign fmt_w = is_priv_w ? RID_FMT_PRIV :
                 is_fop_w ? RID_FMT_FOP :
                 is_iop_w ? RID_FMT_IOP :
                 is_branch_w ? RID_FMT_BRANCH :
                 is_memfn_w ? RID_FMT_MEMFN : RID_FMT_MEM;

  // ----------------------------------------
  // source operand values
  // ----------------------------------------
  wire logic a_zero_w = (sel_a_w == RID_ZERO_SEL);
  wire logic b_zero_w = (sel_b_w == RID_ZERO_SEL);
  wire logic [63:0] int_a_w = a_zero_w ? 64'h0 : regval_i.int_a;
  wire logic [63:0] int_b_reg_w = b_zero_w ? 64'h0 : regval_i.int_b;
  wire logic lit_used_w = is_iop_w && lit_bit_w;
  wire logic [63:0] int_b_w = lit_used_w ? {56'h0, lit_w} : int_b_reg_w;
  wire logic [63:0] fp_a_w = a_zero_w ? 64'h0 : regval_i.fp_a;
  wire logic [63:0] fp_b_w = b_zero_w ? 64'h0 : regval_i.fp_b;
  wire logic [63:0] src_a_w = is_fop_w ? fp_a_w : int_a_w;
  wire logic [63:0] src_b_w = is_fop_w ? fp_b_w : int_b_w;

  // ----------------------------------------
  // address formation
  // ----------------------------------------
  wire logic [63:0] off_w = {{48{disp16_w[15]}}, disp16_w};
  wire logic [63:0] off_high_w = off_w << RID_HIGH_SHIFT;
  wire logic [63:0] mem_addr_w = int_b_reg_w + ((major_w == RID_OP_ADDR_HIGH) ? off_high_w : off_w);
  wire logic [63:0] jump_addr_w = {int_b_reg_w[63:2], 2'b00};
  wire logic [63:0] br_off_w = {{41{disp21_w[20]}}, disp21_w, 2'b00};
  wire logic [63:0] br_addr_w = instruction_pointer_i + br_off_w;
  wire logic [63:0] addr_w = is_branch_w ? br_addr_w : is_jump_w ? jump_addr_w : mem_addr_w;

  // ----------------------------------------
  // function code, destination, exceptions
  // ----------------------------------------
  wire logic [25:0] func_w = is_priv_w ? pfunc_w :
                             is_fop_w ? {15'h0, ffunc_w} :
                             is_iop_w ? {19'h0, ifunc_w} :
                             (is_memfn_w || is_jump_w) ? {10'h0, disp16_w} : 26'h0;
  wire logic [4:0] dest_w = (is_iop_w || is_fop_w) ? sel_c_w : sel_a_w;
  wire logic uncond_w = is_jump_w || (major_w == RID_OP_BR) || (major_w == RID_OP_BSR);
  wire logic discard_w = !is_priv_w && (dest_w == RID_ZERO_SEL) && !uncond_w;
  wire logic illegal_w = trap_major_w && (is_iop_w || is_fop_w) && !func_defined_i;
  wire logic halt_w = is_priv_w && (pfunc_w == 26'h0);
  // function-memory words cannot raise privilege: no path widens access

  rid_dec_t dec_nxt;
  rid_val_t val_nxt;
  assign dec_nxt = '{
    valid: word_valid_i,
    fmt: fmt_w,
    major: major_w,
    sel_a: sel_a_w,
    sel_b: sel_b_w,
    sel_dest: dest_w,
    func: func_w,
    lit_used: lit_used_w,
    halt: halt_w,
    illegal: illegal_w,
    wb_discard: discard_w
  };
  assign val_nxt = '{
    src_a: src_a_w,
    src_b: src_b_w,
    vaddr: addr_w
  };

  // ----------------------------------------
  // output register
  // ----------------------------------------
  rid_dec_t dec_r;
  rid_val_t val_r;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      dec_r <= '0;
    end else if (ce_i) begin
      dec_r <= dec_nxt;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      val_r <= '0;
    end else if (ce_i) begin
      val_r <= val_nxt;
    end
  end
  assign dec_o = dec_r;
  assign val_o = val_r;

  // ----------------------------------------
  // checks: fields and format
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  chk_major_field: assert property (
    ce_i |=> dec_o.major == $past(word_i[31:26]))
    else $error("major code not taken from bits 31:26");

  chk_select_fields: assert property (
    ce_i |=> dec_o.sel_a == $past(word_i[25:21]) && dec_o.sel_b == $past(word_i[20:16]))
    else $error("register selector fields wrong");

  chk_memfn_func: assert property (
    ce_i && is_memfn_w
    |=> dec_o.fmt == RID_FMT_MEMFN && dec_o.func == {10'h0, $past(word_i[15:0])})
    else $error("memory function code wrong");

  chk_branch_fields: assert property (
    ce_i && is_branch_w
    |=> dec_o.fmt == RID_FMT_BRANCH && dec_o.sel_dest == $past(word_i[25:21]))
    else $error("branch fields wrong");

  chk_iop_func: assert property (
    ce_i && is_iop_w
    |=> dec_o.func == {19'h0, $past(word_i[11:5])} && dec_o.sel_dest == $past(word_i[4:0]))
    else $error("operate function or destination wrong");

  chk_fop_fields: assert property (
    ce_i && is_fop_w
    |=> dec_o.fmt == RID_FMT_FOP && dec_o.sel_dest == $past(word_i[4:0]))
    else $error("float operate fields wrong");

  chk_fp_no_literal: assert property (
    ce_i && is_fop_w
    |=> !dec_o.lit_used && dec_o.func == {15'h0, $past(word_i[15:5])})
    else $error("float operate decoded a literal");

  chk_priv_func: assert property (
    ce_i && is_priv_w
    |=> dec_o.fmt == RID_FMT_PRIV && dec_o.func == $past(word_i[25:0]))
    else $error("privileged function field wrong");

  chk_halt_word: assert property (
    ce_i |=> dec_o.halt == ($past(word_i) == 32'h0))
    else $error("halt decode wrong");

  chk_iop_format: assert property (
    ce_i && major_w >= RID_OP_IOP_LO && major_w <= RID_OP_IOP_HI
    |=> dec_o.fmt == RID_FMT_IOP && dec_o.valid == $past(word_valid_i))
    else $error("operate format indicator wrong");

  chk_mem_format: assert property (
    ce_i && major_w == RID_OP_ADDR_HIGH |=> dec_o.fmt == RID_FMT_MEM)
    else $error("memory format indicator wrong");

  // ----------------------------------------
  // checks: operands
  // ----------------------------------------
  chk_zero_first: assert property (
    ce_i && word_i[25:21] == 5'h1F |=> val_o.src_a == 64'h0)
    else $error("selector 31 did not give zero");

  chk_first_reg: assert property (
    ce_i && !is_fop_w && word_i[25:21] != 5'h1F
    |=> val_o.src_a == $past(regval_i.int_a))
    else $error("first integer source wrong");

  chk_literal_value: assert property (
    ce_i && is_iop_w && word_i[12]
    |=> val_o.src_b == {56'h0, $past(word_i[20:13])} && dec_o.lit_used)
    else $error("literal operand wrong");

  chk_lit_unused: assert property (
    ce_i && !is_iop_w |=> !dec_o.lit_used)
    else $error("literal flagged outside operate format");

  chk_zero_second: assert property (
    ce_i && word_i[20:16] == 5'h1F && !(is_iop_w && word_i[12]) && (is_iop_w || is_fop_w)
    |=> val_o.src_b == 64'h0)
    else $error("second selector 31 did not give zero");

  chk_second_reg: assert property (
    ce_i && is_iop_w && !word_i[12] && word_i[20:16] != 5'h1F
    |=> val_o.src_b == $past(regval_i.int_b))
    else $error("second integer source wrong");

  chk_fp_sources: assert property (
    ce_i && is_fop_w && word_i[25:21] != 5'h1F && word_i[20:16] != 5'h1F
    |=> val_o.src_a == $past(regval_i.fp_a) && val_o.src_b == $past(regval_i.fp_b))
    else $error("float sources wrong");

  // ----------------------------------------
  // checks: addresses
  // ----------------------------------------
  chk_mem_address: assert property (
    ce_i && fmt_w == RID_FMT_MEM && !is_jump_w && major_w != RID_OP_ADDR_HIGH
    |=> val_o.vaddr == $past(int_b_reg_w) + {{48{$past(word_i[15])}}, $past(word_i[15:0])})
    else $error("memory address wrong");

  chk_high_address: assert property (
    ce_i && major_w == RID_OP_ADDR_HIGH
    |=> val_o.vaddr == $past(int_b_reg_w) + {{32{$past(word_i[15])}}, $past(word_i[15:0]), 16'h0})
    else $error("high address wrong");

  chk_jump_hint: assert property (
    ce_i && is_jump_w
    |=> val_o.vaddr == (($past(word_i[20:16]) == 5'h1F) ? 64'h0 : $past(regval_i.int_b) & ~64'h3)
      && dec_o.func == {10'h0, $past(word_i[15:0])})
    else $error("jump target used the hint");

  chk_branch_target: assert property (
    ce_i && is_branch_w
    |=> val_o.vaddr == $past(instruction_pointer_i) + {{41{$past(word_i[20])}}, $past(word_i[20:0]), 2'b00})
    else $error("branch target wrong");

  // ----------------------------------------
  // checks: traps and write-back
  // ----------------------------------------
  chk_illegal_trap: assert property (
    ce_i && is_iop_w && RID_TRAP_MAJORS[major_w] && !func_defined_i
    |=> dec_o.illegal)
    else $error("unused function code did not trap");

  chk_defined_clean: assert property (
    ce_i && func_defined_i |=> !dec_o.illegal)
    else $error("defined function code trapped");

  chk_untrapped_major: assert property (
    ce_i && !trap_major_w |=> !dec_o.illegal)
    else $error("unlisted major code trapped");

  chk_fop_trap: assert property (
    ce_i && is_fop_w && trap_major_w && !func_defined_i
    |=> dec_o.illegal)
    else $error("unused float function code did not trap");

  chk_discard_dest: assert property (
    ce_i && is_jump_w |=> !dec_o.wb_discard)
    else $error("jump to zero register was discarded");

  chk_discard_uncond: assert property (
    ce_i && (major_w == RID_OP_BR || major_w == RID_OP_BSR)
    |=> !dec_o.wb_discard)
    else $error("unconditional branch was discarded");

  chk_discard_zero: assert property (
    ce_i && (is_iop_w || is_fop_w) && word_i[4:0] == 5'h1F
    |=> dec_o.wb_discard)
    else $error("zero register result not discarded");

  chk_priv_keep: assert property (
    ce_i && is_priv_w |=> !dec_o.wb_discard)
    else $error("privileged call was discarded");

  // ----------------------------------------
  // checks: enable and reset
  // ----------------------------------------
  chk_hold_freeze: assert property (
    !ce_i |=> $stable(dec_o) && $stable(val_o))
    else $error("outputs moved while clock enable low");

  chk_reset_clear: assert property (
    disable iff (1'b0) !rst_n_i |=> dec_o == '0 && val_o == '0)
    else $error("outputs not cleared by reset");

  // ----------------------------------------
  // covers
  // ----------------------------------------
  cov_branch: cover property (ce_i && word_valid_i && is_branch_w);
  cov_literal: cover property (ce_i && word_valid_i && lit_used_w);
  cov_trap: cover property (ce_i && word_valid_i && illegal_w);
  cov_halt: cover property (ce_i && word_valid_i && halt_w);
  cov_jump: cover property (ce_i && word_valid_i && is_jump_w);
endmodule : rid_decoder

// ### bench/rid_fetch_model.sv
// partner: fetch side register file that supplies source contents
`timescale 1ns/1ps
module rid_fetch_model (
  input wire logic clk_sys_i,
  input wire logic [31:0] word_i,
  output rid_pkg::rid_regval_t regval_o
);
  import rid_pkg::*;
  logic [63:0] rf_r [64];
  int unsigned k = 0;
  initial for (int i = 0; i < 64; i++) begin
    rf_r[i] = 64'h9E37_79B9_7F4A_7C15 * (i + 1);
  end
  // contents keep moving so stale values show; entry 31 is not zero here
  always @(negedge clk_sys_i) begin
    k = (k + 7) % 64;
    rf_r[k] <= ~rf_r[k];
  end
  assign regval_o = {rf_r[word_i[25:21]], rf_r[word_i[20:16]], rf_r[32 + word_i[25:21]], rf_r[32 + word_i[20:16]]};
endmodule : rid_fetch_model

// ### bench/risc_instruction_format_decoder_tb.sv
// testbench: random and directed words against a behavioural decode model
`timescale 1ns/1ps
module risc_instruction_format_decoder_tb;
  import rid_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b0;
  logic word_valid_i = 1'b0;
  logic [31:0] word_i = 32'h0;
  logic [63:0] instruction_pointer_i = 64'h0;
  logic func_defined_i = 1'b0;
  rid_regval_t regval_i;
  rid_dec_t dec_o, exp_d;
  rid_val_t val_o, exp_v;
  int err_total = 0;
  int checks_done = 0;
  integer seed = 25628;
  logic [31:0] dir_q [$] = '{32'h0, 32'h27FF_8000, 32'hC3FF_FFFF, 32'h6BE1_4000, 32'h43E1_F403, 32'h5BE2_0781};
  always #12.5 clk_sys_i = ~clk_sys_i;
  rid_fetch_model rid_fetch_model_inst (.clk_sys_i(clk_sys_i), .word_i(word_i), .regval_o(regval_i));
  rid_decoder rid_decoder_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .word_valid_i(word_valid_i),
    .word_i(word_i), .instruction_pointer_i(instruction_pointer_i), .func_defined_i(func_defined_i),
    .regval_i(regval_i), .dec_o(dec_o), .val_o(val_o));
  // ----------------------------------------
  // reference decode
  // ----------------------------------------
  task automatic predict();
    logic [31:0] w;
    logic [5:0] m;
    logic [63:0] bz;
    logic iop, fop;
    w = word_i;
    m = w[31:26];
    fop = m >= 6'h14 && m <= 6'h17;
    iop = (m >= 6'h10 && m <= 6'h13) || (RID_TRAP_MAJORS[m] && !fop);
    bz = (w[20:16] == 5'h1F) ? 64'h0 : regval_i.int_b;
    exp_d = '0;
    exp_d.valid = word_valid_i;
    exp_d.fmt = (m == 6'h00) ? RID_FMT_PRIV : fop ? RID_FMT_FOP : iop ? RID_FMT_IOP :
      (m >= 6'h30) ? RID_FMT_BRANCH : (m == 6'h18) ? RID_FMT_MEMFN : RID_FMT_MEM;
    exp_d.major = m;
    exp_d.sel_a = w[25:21];
    exp_d.sel_b = w[20:16];
    exp_d.sel_dest = (iop || fop) ? w[4:0] : w[25:21];
    exp_d.func = (m == 6'h00) ? w[25:0] : fop ? 26'(w[15:5]) : iop ? 26'(w[11:5]) :
      (m == 6'h18 || m == 6'h1A) ? 26'(w[15:0]) : 26'h0;
    exp_d.lit_used = iop && w[12];
    exp_d.halt = w == 32'h0;
    exp_d.illegal = RID_TRAP_MAJORS[m] && (iop || fop) && !func_defined_i;
    exp_d.wb_discard = exp_d.sel_dest == 5'h1F && m != 6'h00 && m != 6'h1A && m != 6'h30 && m != 6'h34;
    exp_v.src_a = (w[25:21] == 5'h1F) ? 64'h0 : fop ? regval_i.fp_a : regval_i.int_a;
    exp_v.src_b = (iop && w[12]) ? 64'(w[20:13]) : (w[20:16] == 5'h1F) ? 64'h0 : fop ? regval_i.fp_b : bz;
    exp_v.vaddr = (m >= 6'h30) ? instruction_pointer_i + {{41{w[20]}}, w[20:0], 2'h0} :
      (m == 6'h1A) ? bz & ~64'h3 : (m == 6'h09) ? bz + {{32{w[15]}}, w[15:0], 16'h0} : bz + {{48{w[15]}}, w[15:0]};
  endtask : predict
  task automatic cmp_dec(input rid_dec_t got, input rid_dec_t want);
    checks_done++;
    if (got !== want) begin
      err_total++;
      $display("MISMATCH dec t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : cmp_dec
  task automatic cmp_val(input rid_val_t got, input rid_val_t want);
    checks_done++;
    if (got !== want) begin
      err_total++;
      $display("MISMATCH val t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : cmp_val
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    exp_d = '0;
    exp_v = '0;
    repeat (5) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    for (int i = 0; i < 900; i++) begin
      @(negedge clk_sys_i);
      cmp_dec(dec_o, exp_d);
      cmp_val(val_o, exp_v);
      ce_i = (i < dir_q.size()) || (($random(seed) % 4) != 0);
      word_valid_i = 1'($random(seed));
      func_defined_i = 1'($random(seed));
      instruction_pointer_i = {$random(seed), $random(seed)} & ~64'h3;
      word_i = (i < dir_q.size()) ? dir_q[i] : $random(seed);
      if (i % 3 == 1) word_i[25:21] = 5'h1F;
      if (i % 5 == 2) word_i[20:16] = 5'h1F;
      rst_n_i = !(i == 450 || i == 451);
      #1;
      if (!rst_n_i) begin
        exp_d = '0;
        exp_v = '0;
      end else if (ce_i) begin
        predict();
      end
    end
    conclude();
  end
  initial begin
    #(25 * 100000);
    err_total++;
    conclude();
  end
endmodule : risc_instruction_format_decoder_tb
